// >>> include/ext_irq_pkg.sv
// Purpose: Shared constants and types for the external interrupt pin interface.
// Assumes: One 10 MHz system clock, asynchronous active-low reset.
// Notes: Types of sources 0 to 4 are defaults; priority is fixed by source index.
package ext_irq_pkg;

    localparam int NUM_SRC = 7;
    localparam int NUM_PINS = 9;
    localparam int NUM_TRIG = 5;
    localparam int TYPE_W = 8;

    // Pin index of each synchroniser in the bank.
    localparam int PIN_REQ0 = 0;
    localparam int PIN_REQ1 = 1;
    localparam int PIN_REQ2 = 2;
    localparam int PIN_REQ3 = 3;
    localparam int PIN_REQ4 = 4;
    localparam int PIN_DMA0 = 5;
    localparam int PIN_DMA1 = 6;
    localparam int PIN_TMR0 = 7;
    localparam int PIN_TMR1 = 8;

    // Vector types, index 0 in the low byte. Sources 0 to 4 are plain defaults.
    localparam logic [NUM_SRC-1:0][TYPE_W-1:0] VEC_TYPES =
        {8'h0b, 8'h0a, 8'h10, 8'h0f, 8'h0e, 8'h0d, 8'h0c};

    // Cycles that a cascade acknowledge is held before the type is sampled.
    localparam int ACK_HOLD_CYCLES = 2;

    localparam logic [TYPE_W-1:0] TYPE_RESET = 8'h00;
    localparam logic [NUM_SRC-1:0] PEND_RESET = 7'h00;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CASCADE
    } seq_state_t;

endpackage : ext_irq_pkg

// >>> rtl/req_sync.sv
// Purpose: Two-stage synchroniser for one pin with registered edge pulses.
// Assumes: The pin is asynchronous to clock.
// Notes: Edges are taken between the second and third stage only.
module req_sync (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic async_in,
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic rise;
        logic fall;
    } sync_t;

    sync_t cur_ff;
    sync_t nxt_ff;

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.s1 = async_in;
        nxt_ff.s2 = cur_ff.s1;
        nxt_ff.s3 = cur_ff.s2;
        nxt_ff.rise = cur_ff.s2 & ~cur_ff.s3;
        nxt_ff.fall = ~cur_ff.s2 & cur_ff.s3;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign level = cur_ff.s2;
    assign rise = cur_ff.rise;
    assign fall = cur_ff.fall;
endmodule : req_sync

// >>> rtl/ext_irq_pins.sv
// Purpose: External request side of the interrupt unit: pins, cascade, slave, demodulation.
// Assumes: Configuration inputs are static from the system clock domain; ext_type_in is
//          synchronous to clock and valid while an acknowledge or select is active.
// Notes: Fixed priority, lowest source index first; acknowledge pins are active low.
module ext_irq_pins #(
    parameter int ACK_CYCLES = ext_irq_pkg::ACK_HOLD_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ext_req_zero,
    input wire logic ext_req_one,
    input wire logic ext_req_two_in,
    output logic ext_req_two_out,
    output logic ext_req_two_oe,
    input wire logic ext_req_three_in,
    output logic ext_req_three_out,
    output logic ext_req_three_oe,
    input wire logic ext_req_four,
    input wire logic dma0_shared_req,
    input wire logic dma1_shared_req,
    input wire logic timer0_input,
    input wire logic timer1_input,
    input wire logic [ext_irq_pkg::NUM_TRIG-1:0] level_trigger,
    input wire logic [ext_irq_pkg::NUM_SRC-1:0] req_mask,
    input wire logic cascade_zero_en,
    input wire logic cascade_one_en,
    input wire logic slave_mode_en,
    input wire logic demod_en,
    input wire logic dma0_enabled,
    input wire logic dma0_ext_sync,
    input wire logic dma1_enabled,
    input wire logic dma1_ext_sync,
    input wire logic slave_irq_request,
    input wire logic core_ack,
    input wire logic [ext_irq_pkg::TYPE_W-1:0] ext_type_in,
    output logic irq_to_core,
    output logic [ext_irq_pkg::TYPE_W-1:0] irq_type,
    output logic irq_type_valid,
    output logic [ext_irq_pkg::NUM_SRC-1:0] req_pending,
    output logic timer0_route,
    output logic timer1_route,
    output logic gp_io_bit_31
);
    import ext_irq_pkg::*;

    localparam int CNT_W = (ACK_CYCLES > 1) ? $clog2(ACK_CYCLES) : 1;

    if (ACK_CYCLES < 1 || ACK_CYCLES > 256) begin : g_bad_ack
        $error("ACK_CYCLES must lie between 1 and 256.");
    end

    typedef struct packed {
        seq_state_t st;
        logic [NUM_SRC-1:0] pend;
        logic irq_out;
        logic [TYPE_W-1:0] type_q;
        logic type_valid;
        logic [2:0] win;
        logic [CNT_W-1:0] cnt;
        logic pin2_out;
        logic pin2_oe;
        logic pin3_out;
        logic pin3_oe;
        logic t0;
        logic t1;
        logic gpio31;
    } ctl_t;

    ctl_t cur_ff;
    ctl_t nxt_ff;

    logic [NUM_PINS-1:0] pin_raw;
    logic [NUM_PINS-1:0] pin_lvl;
    logic [NUM_PINS-1:0] pin_rise;
    logic [NUM_PINS-1:0] pin_fall;

    assign pin_raw = {timer1_input, timer0_input, dma1_shared_req, dma0_shared_req,
                      ext_req_four, ext_req_three_in, ext_req_two_in, ext_req_one,
                      ext_req_zero};

    // Every pin, the demodulator included, is synchronised before use.
    for (genvar gi = 0; gi < NUM_PINS; gi++) begin : g_sync
        req_sync u_sync (
            .clock(clock),
            .rst_n(rst_n),
            .async_in(pin_raw[gi]),
            .level(pin_lvl[gi]),
            .rise(pin_rise[gi]),
            .fall(pin_fall[gi])
        );
    end

    logic dma0_int_ok;
    logic dma1_int_ok;
    logic pin3_is_request;
    logic [NUM_SRC-1:0] src_lvl;
    logic [NUM_SRC-1:0] src_edge;
    logic [NUM_SRC-1:0] level_mode;
    logic [NUM_SRC-1:0] eligible;
    logic any_eligible;
    logic [2:0] top_src;

    assign dma0_int_ok = ~dma0_enabled | ~dma0_ext_sync;
    assign dma1_int_ok = ~dma1_enabled | ~dma1_ext_sync;
    assign pin3_is_request = ~cascade_one_en & ~slave_mode_en;

    // The shared pins never take the level setting.
    assign level_mode = {2'b00, level_trigger};

    always_comb begin
        src_lvl = '0;
        src_edge = '0;
        src_lvl[0] = pin_lvl[PIN_REQ0];
        src_edge[0] = pin_rise[PIN_REQ0];
        // In slave mode the second pin is the select strobe, not a request.
        src_lvl[1] = pin_lvl[PIN_REQ1] & ~slave_mode_en;
        src_edge[1] = pin_rise[PIN_REQ1] & ~slave_mode_en;
        // Cascade takes the third pin away from request duty; demodulation feeds it straight.
        src_lvl[2] = pin_lvl[PIN_REQ2] & ~cascade_zero_en;
        src_edge[2] = pin_rise[PIN_REQ2] & ~cascade_zero_en;
        src_lvl[3] = pin_lvl[PIN_REQ3] & pin3_is_request;
        src_edge[3] = pin_rise[PIN_REQ3] & pin3_is_request;
        if (demod_en) begin
            // The request-4 pin is ignored; its slot tracks the inverted demodulator.
            src_lvl[4] = ~pin_lvl[PIN_REQ2];
            src_edge[4] = pin_fall[PIN_REQ2];
        end else begin
            src_lvl[4] = pin_lvl[PIN_REQ4];
            src_edge[4] = pin_rise[PIN_REQ4];
        end
        src_edge[5] = pin_rise[PIN_DMA0] & dma0_int_ok;
        src_edge[6] = pin_rise[PIN_DMA1] & dma1_int_ok;
    end

    // Outside slave mode, masking gates the choice and the core request; the pending bit itself is kept.
    assign eligible = cur_ff.pend & ~req_mask;
    assign any_eligible = |eligible;

    always_comb begin
        top_src = 3'd0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                top_src = 3'(i);
            end
        end
    end

    logic [NUM_SRC-1:0] clr;
    logic win_cascade_zero;
    logic win_cascade_one;

    assign win_cascade_zero = (top_src == 3'd0) && cascade_zero_en;
    assign win_cascade_one = (top_src == 3'd1) && cascade_one_en && !slave_mode_en;

    always_comb begin
        nxt_ff = cur_ff;
        clr = '0;
        nxt_ff.type_valid = 1'b0;

        case (cur_ff.st)
            SEQ_IDLE: begin
                if (slave_mode_en) begin
                    // The master's request on pin 0 comes first; select then marks the type.
                    if (pin_rise[PIN_REQ1] && pin_lvl[PIN_REQ0]) begin
                        nxt_ff.type_q = ext_type_in;
                        nxt_ff.type_valid = 1'b1;
                        clr[0] = 1'b1;
                    end
                end else if (core_ack && any_eligible) begin
                    nxt_ff.win = top_src;
                    if (win_cascade_zero || win_cascade_one) begin
                        nxt_ff.st = SEQ_CASCADE;
                        nxt_ff.cnt = CNT_W'(ACK_CYCLES - 1);
                    end else begin
                        nxt_ff.type_q = VEC_TYPES[top_src];
                        nxt_ff.type_valid = 1'b1;
                        clr[top_src] = 1'b1;
                    end
                end
            end
            SEQ_CASCADE: begin
                if (cur_ff.cnt == '0) begin
                    // The peripheral's type is taken on the last acknowledge cycle.
                    nxt_ff.type_q = ext_type_in;
                    nxt_ff.type_valid = 1'b1;
                    clr[cur_ff.win] = 1'b1;
                    nxt_ff.st = SEQ_IDLE;
                end else begin
                    nxt_ff.cnt = cur_ff.cnt - CNT_W'(1);
                end
            end
            default: begin
                nxt_ff.st = SEQ_IDLE;
            end
        endcase

        // A new edge in the clearing cycle wins, so no request is lost.
        for (int i = 0; i < NUM_SRC; i++) begin
            if (level_mode[i]) begin
                nxt_ff.pend[i] = src_lvl[i];
            end else begin
                nxt_ff.pend[i] = (cur_ff.pend[i] & ~clr[i]) | src_edge[i];
            end
        end

        if (slave_mode_en) begin
            nxt_ff.irq_out = pin_lvl[PIN_REQ0];
        end else begin
            nxt_ff.irq_out = |(nxt_ff.pend & ~req_mask) && (nxt_ff.st == SEQ_IDLE);
        end

        // Pin drivers: acknowledges are low while the sequencer waits for a type.
        nxt_ff.pin2_oe = cascade_zero_en;
        nxt_ff.pin2_out = !((nxt_ff.st == SEQ_CASCADE) && (nxt_ff.win == 3'd0));
        nxt_ff.pin3_oe = cascade_one_en | slave_mode_en;
        if (slave_mode_en) begin
            nxt_ff.pin3_out = slave_irq_request;
        end else begin
            nxt_ff.pin3_out = !((nxt_ff.st == SEQ_CASCADE) && (nxt_ff.win == 3'd1));
        end

        // Timer inputs come from the demodulator while it is enabled.
        if (demod_en) begin
            nxt_ff.t0 = pin_lvl[PIN_REQ2];
            nxt_ff.t1 = ~pin_lvl[PIN_REQ2];
        end else begin
            nxt_ff.t0 = pin_lvl[PIN_TMR0];
            nxt_ff.t1 = pin_lvl[PIN_TMR1];
        end
        nxt_ff.gpio31 = pin_lvl[PIN_REQ2];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff.st <= SEQ_IDLE;
            cur_ff.pend <= PEND_RESET;
            cur_ff.irq_out <= 1'b0;
            cur_ff.type_q <= TYPE_RESET;
            cur_ff.type_valid <= 1'b0;
            cur_ff.win <= 3'd0;
            cur_ff.cnt <= '0;
            cur_ff.pin2_out <= 1'b1;
            cur_ff.pin2_oe <= 1'b0;
            cur_ff.pin3_out <= 1'b1;
            cur_ff.pin3_oe <= 1'b0;
            cur_ff.t0 <= 1'b0;
            cur_ff.t1 <= 1'b0;
            cur_ff.gpio31 <= 1'b0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign ext_req_two_out = cur_ff.pin2_out;
    assign ext_req_two_oe = cur_ff.pin2_oe;
    assign ext_req_three_out = cur_ff.pin3_out;
    assign ext_req_three_oe = cur_ff.pin3_oe;
    assign irq_to_core = cur_ff.irq_out;
    assign irq_type = cur_ff.type_q;
    assign irq_type_valid = cur_ff.type_valid;
    assign req_pending = cur_ff.pend;
    assign timer0_route = cur_ff.t0;
    assign timer1_route = cur_ff.t1;
    assign gp_io_bit_31 = cur_ff.gpio31;
endmodule : ext_irq_pins

// >>> dv/irq_chk.sv
// Purpose: Concurrent checks on the external request pin block.
// Assumes: Mode inputs are static while a transfer runs.
// Notes: Bound to every instance of the block.
module irq_chk #(
    parameter int ACK_CYCLES = 2
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic core_ack,
    input wire logic cascade_zero_en,
    input wire logic cascade_one_en,
    input wire logic slave_mode_en,
    input wire logic demod_en,
    input wire logic slave_irq_request,
    input wire logic [ext_irq_pkg::NUM_SRC-1:0] req_mask,
    input wire logic [ext_irq_pkg::NUM_SRC-1:0] req_pending,
    input wire logic irq_to_core,
    input wire logic irq_type_valid,
    input wire logic ext_req_two_out,
    input wire logic ext_req_two_oe,
    input wire logic ext_req_three_out,
    input wire logic ext_req_three_oe,
    input wire logic timer0_route,
    input wire logic timer1_route,
    input wire logic gp_io_bit_31
);
    timeunit 1ns;
    timeprecision 1ns;
    import ext_irq_pkg::*;
    logic [8:0] low_ff;
    logic up_ff;
    // Registered outputs still show reset values at the first edge, so the pin-three checks wait for up_ff.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            low_ff <= 9'h000;
            up_ff <= 1'b0;
        end else begin
            low_ff <= ext_req_two_out ? 9'h000 : low_ff + 9'h001;
            up_ff <= 1'b1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_ack_cause: assert property ($fell(ext_req_two_out) |-> $past(core_ack) && cascade_zero_en)
        else $error("cascade acknowledge without a taken request");
    a_ack_width: assert property ($rose(ext_req_two_out) |-> low_ff == ACK_CYCLES && irq_type_valid)
        else $error("cascade acknowledge has the wrong length");
    a_ack_drives: assert property (!ext_req_two_out |-> ext_req_two_oe)
        else $error("acknowledge low on an undriven pin");
    a_wait_quiet: assert property (!ext_req_two_out |-> !irq_to_core)
        else $error("core request while a type is awaited");
    a_mask_gate: assert property (irq_to_core && !slave_mode_en |-> |(req_pending & ~req_mask))
        else $error("core request without an unmasked pending source");
    a_demod_split: assert property ($past(demod_en) |-> timer1_route != timer0_route)
        else $error("timer routes not complementary");
    a_gpio_mirror: assert property ($past(demod_en) |-> gp_io_bit_31 == timer0_route)
        else $error("data bit does not follow the demodulator pin");
    a_slave_fwd: assert property (up_ff && $past(slave_mode_en) |-> ext_req_three_oe
        && ext_req_three_out == $past(slave_irq_request))
        else $error("slave request not forwarded");
    a_pin3_idle: assert property (up_ff && !$past(cascade_one_en) && !$past(slave_mode_en)
        |-> !ext_req_three_oe)
        else $error("pin three driven outside its modes");
    c_cascade: cover property ($rose(ext_req_two_out));
    c_slave: cover property (slave_mode_en && irq_type_valid);
    c_demod: cover property (demod_en && req_pending[4]);
endmodule : irq_chk

bind ext_irq_pins irq_chk #(.ACK_CYCLES(ACK_CYCLES)) i_irq_chk (.*);

// >>> dv/ext_periph_model.sv
// Purpose: Peripheral and master controller that supply a vector type on the bus.
// Assumes: ack and sel are already resolved pin levels.
// Notes: Off the bus the lines flip every cycle, so a sample one cycle after the bus reads ~VEC, and one two cycles after reads VEC.
module ext_periph_model #(
    parameter logic [7:0] VEC = 8'h5a
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ack,
    input wire logic sel,
    output logic [7:0] type_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] junk_ff;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) junk_ff <= 8'h00;
        else junk_ff <= ~type_out;
    end
    assign type_out = (ack || sel) ? VEC : junk_ff;
endmodule : ext_periph_model

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the external request pin block.
// Assumes: Default acknowledge hold; the partner supplies cascade and slave types.
// Notes: Every scenario after t_each_source ends in a fresh reset so leftovers cannot hide a fault.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ext_irq_pkg::*;
    localparam logic [7:0] EXT_VEC = 8'h5a;
    logic clock = 1'b0;
    logic rst_n, ext_req_zero, ext_req_one, ext_req_two_in, ext_req_three_in, ext_req_four;
    logic dma0_shared_req, dma1_shared_req, timer0_input, timer1_input, cascade_zero_en;
    logic cascade_one_en, slave_mode_en, demod_en, dma0_enabled, dma0_ext_sync, dma1_enabled;
    logic dma1_ext_sync, slave_irq_request, core_ack, irq_to_core, irq_type_valid, cas_ack;
    logic ext_req_two_out, ext_req_two_oe, ext_req_three_out, ext_req_three_oe;
    logic timer0_route, timer1_route, gp_io_bit_31;
    logic [4:0] level_trigger;
    logic [6:0] req_mask, req_pending, pins;
    logic [7:0] ext_type_in, irq_type;
    int n_errors = 0;
    int n_compared = 0;
    // Pins 2 and 3 are two-way: the wire carries the block's level while it drives.
    assign ext_req_two_in = ext_req_two_oe ? ext_req_two_out : pins[2];
    assign ext_req_three_in = ext_req_three_oe ? ext_req_three_out : pins[3];
    assign {dma1_shared_req, dma0_shared_req, ext_req_four} = pins[6:4];
    assign {ext_req_one, ext_req_zero} = pins[1:0];
    assign cas_ack = (ext_req_two_oe && !ext_req_two_out)
        || (ext_req_three_oe && !ext_req_three_out && !slave_mode_en);
    ext_irq_pins i_ext_irq_pins (.*);
    ext_periph_model #(.VEC(EXT_VEC)) i_ext_periph_model (.clock(clock), .rst_n(rst_n),
        .ack(cas_ack), .sel(ext_req_one && slave_mode_en), .type_out(ext_type_in));
    always #50 clock = ~clock;

    task automatic summarize;
        if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc

    task automatic wait_on(input bit on_valid);
        // Checked before waiting: the one-cycle type pulse may already stand on entry.
        for (int i = 0; i < 30; i++) begin
            if ((on_valid ? irq_type_valid : irq_to_core) === 1'b1) return;
            @(negedge clock);
        end
        chk(8'h00, 8'h01);
        summarize();
    endtask : wait_on

    task automatic take;
        core_ack = 1'b1;
        cyc(1);
        core_ack = 1'b0;
    endtask : take

    task automatic do_reset;
        rst_n = 1'b0;
        pins = 7'h00;
        {cascade_zero_en, cascade_one_en, slave_mode_en, demod_en, dma0_enabled} = 5'h00;
        {dma0_ext_sync, dma1_enabled, dma1_ext_sync, slave_irq_request, core_ack} = 5'h00;
        {timer0_input, timer1_input} = 2'h0;
        level_trigger = 5'h00;
        req_mask = 7'h00;
        cyc(6);
        chk({ext_req_two_out, ext_req_three_out, irq_to_core, irq_type_valid}, 8'h0c);
        chk(irq_type, 8'h00);
        rst_n = 1'b1;
        cyc(2);
    endtask : do_reset

    task automatic t_each_source;
        for (int i = 0; i < NUM_SRC; i++) begin
            pins[i] = 1'b1;
            wait_on(1'b0);
            take();
            wait_on(1'b1);
            chk(irq_type, VEC_TYPES[i]);
            chk(req_pending, 8'h00);
            pins[i] = 1'b0;
            cyc(3);
        end
    endtask : t_each_source

    task automatic t_mask_dma;
        req_mask = 7'h08;
        dma0_enabled = 1'b1;
        dma0_ext_sync = 1'b1;
        pins = 7'h28;
        cyc(6);
        chk(req_pending, 8'h08);
        chk(irq_to_core, 8'h00);
        req_mask = 7'h00;
        cyc(2);
        chk(irq_to_core, 8'h01);
        do_reset();
    endtask : t_mask_dma

    task automatic t_level;
        level_trigger = 5'h01;
        pins = 7'h03;
        cyc(6);
        chk(req_pending, 8'h03);
        pins = 7'h00;
        cyc(6);
        chk(req_pending, 8'h02);
        do_reset();
    endtask : t_level

    task automatic t_cascade;
        for (int k = 0; k < 2; k++) begin
            cascade_zero_en = (k == 0);
            cascade_one_en = (k == 1);
            cyc(2);
            pins[k] = 1'b1;
            wait_on(1'b0);
            take();
            wait_on(1'b1);
            chk(irq_type, EXT_VEC);
            do_reset();
        end
    endtask : t_cascade

    task automatic t_slave;
        slave_mode_en = 1'b1;
        slave_irq_request = 1'b1;
        cyc(3);
        chk({ext_req_three_oe, ext_req_three_out}, 8'h03);
        pins[0] = 1'b1;
        cyc(4);
        chk(irq_to_core, 8'h01);
        pins[1] = 1'b1;
        wait_on(1'b1);
        chk(irq_type, EXT_VEC);
        do_reset();
    endtask : t_slave

    task automatic t_demod;
        demod_en = 1'b1;
        {timer0_input, timer1_input} = 2'h3;
        pins = 7'h14;
        cyc(5);
        chk({timer0_route, timer1_route, gp_io_bit_31}, 8'h05);
        chk(req_pending, 8'h04);
        pins = 7'h10;
        cyc(5);
        chk({timer0_route, timer1_route, gp_io_bit_31}, 8'h02);
        chk(req_pending, 8'h14);
        do_reset();
    endtask : t_demod

    initial begin
        do_reset();
        t_each_source();
        t_mask_dma();
        t_level();
        t_cascade();
        t_slave();
        t_demod();
        summarize();
    end
endmodule : testbench
